// ==== design/power_guard.sv ====
// power enable register bank with thermal guard behind a two-wire control port
// assumes SCL/SDA and the sensor comparator are asynchronous pins; the
// speaker request comes from logic on SYS_CLK; SDA is open drain outside
`timescale 1ns/1ns
`default_nettype none
module power_guard (
  input  wire logic SYS_CLK,
  input  wire logic RST,
  input  wire logic SCL_IN,
  input  wire logic SDA_IN,
  output logic      SDA_OUT,
  output logic      SDA_OE,
  input  wire logic OVERTEMP_DET,
  input  wire logic SPK_OUT_REQ,
  output logic      SPK_OUT_POS_EN,
  output logic      SPK_OUT_NEG_EN,
  output logic      OVERTEMP_FLAG,
  output logic      TEMP_SENSOR_EN,
  output logic      INPUT2_NEG_GAIN_EN,
  output logic      SPK_GAIN_STAGE_EN,
  output logic      HP_LEFT_MIXER_EN,
  output logic      HP_RIGHT_MIXER_EN,
  output logic      SPK_MIXER_EN,
  output logic      STARTUP_BIAS_EN,
  output logic      WRITE_SEQUENCER_EN,
  output logic      CHARGE_PUMP_EN,
  output logic      DC_SERVO_LEFT_EN,
  output logic      DC_SERVO_RIGHT_EN
);
  import power_guard_pkg::*;
  typedef struct packed {
    logic [2:0]  scl_sync;
    logic [2:0]  sda_sync;
    logic [2:0]  det_sync;
    logic        scl_f;
    logic        sda_f;
    logic        det_f;
    port_state_t state;
    logic [3:0]  cnt;
    logic [7:0]  shift;
    logic        rw;
    logic [7:0]  ptr;
    logic [7:0]  data_hi;
    logic        sda_drive;
    logic        flag;
    logic        spk_drv;
    logic        temp_sensor_en;
    logic        overtemp_output_cut;
    logic        input2_neg_gain_en;
    logic        spk_gain_stage_en;
    logic        hp_left_mixer_en;
    logic        hp_right_mixer_en;
    logic        spk_mixer_en;
    logic        startup_bias_en;
    logic        write_sequencer_en;
    logic        charge_pump_en;
    logic        dc_servo_left_en;
    logic        dc_servo_right_en;
  } guard_state_t;
  localparam guard_state_t STATE_RST = '{
    scl_sync: 3'h7, sda_sync: 3'h7, det_sync: 3'h0,
    scl_f: 1'b1, sda_f: 1'b1, det_f: 1'b0,
    state: ST_IDLE, cnt: 4'h0, shift: 8'h00, rw: 1'b0,
    ptr: 8'h00, data_hi: 8'h00, sda_drive: 1'b0,
    flag: 1'b0, spk_drv: 1'b0,
    temp_sensor_en: TEMP_SENSOR_EN_RST,
    overtemp_output_cut: OVERTEMP_OUTPUT_CUT_RST,
    input2_neg_gain_en: ENABLE_RST, spk_gain_stage_en: ENABLE_RST,
    hp_left_mixer_en: ENABLE_RST, hp_right_mixer_en: ENABLE_RST,
    spk_mixer_en: ENABLE_RST, startup_bias_en: ENABLE_RST,
    write_sequencer_en: ENABLE_RST, charge_pump_en: ENABLE_RST,
    dc_servo_left_en: ENABLE_RST, dc_servo_right_en: ENABLE_RST
  };
  guard_state_t s_reg;
  guard_state_t s_next;
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic        scl_new;
    logic        sda_new;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_cond;
    logic        stop_cond;
    logic        wr_en;
    logic [15:0] wr_data;
    logic [15:0] rd_word;
    logic [7:0]  shifted;
    s_next     = s_reg;
    wr_en      = 1'b0;
    wr_data    = {s_reg.data_hi, s_reg.shift};
    shifted    = {s_reg.shift[6:0], 1'b0};
    rd_word    = 16'h0000;
    // three-stage pin filters, second and third stage must agree
    scl_new    = (s_reg.scl_sync[1] == s_reg.scl_sync[2]) ? s_reg.scl_sync[2] : s_reg.scl_f;
    sda_new    = (s_reg.sda_sync[1] == s_reg.sda_sync[2]) ? s_reg.sda_sync[2] : s_reg.sda_f;
    scl_rise   = scl_new & ~s_reg.scl_f;
    scl_fall   = ~scl_new & s_reg.scl_f;
    start_cond = s_reg.scl_f & scl_new & s_reg.sda_f & ~sda_new;
    stop_cond  = s_reg.scl_f & scl_new & ~s_reg.sda_f & sda_new;
    s_next.scl_sync = {s_reg.scl_sync[1:0], SCL_IN};
    s_next.sda_sync = {s_reg.sda_sync[1:0], SDA_IN};
    s_next.det_sync = {s_reg.det_sync[1:0], OVERTEMP_DET};
    s_next.det_f    = (s_reg.det_sync[1] == s_reg.det_sync[2]) ? s_reg.det_sync[2] : s_reg.det_f;
    s_next.scl_f    = scl_new;
    s_next.sda_f    = sda_new;
    // read-only status bit and the enable fields read back, other bits read zero
    unique case (s_reg.ptr)
      POWER_CONTROL_TWO_OFS: begin
        rd_word[OVERTEMP_FLAG_BIT]       = s_reg.flag;
        rd_word[TEMP_SENSOR_EN_BIT]      = s_reg.temp_sensor_en;
        rd_word[OVERTEMP_OUTPUT_CUT_BIT] = s_reg.overtemp_output_cut;
        rd_word[INPUT2_NEG_GAIN_EN_BIT]  = s_reg.input2_neg_gain_en;
      end
      POWER_CONTROL_THREE_OFS: begin
        rd_word[SPK_GAIN_STAGE_EN_BIT] = s_reg.spk_gain_stage_en;
        rd_word[HP_LEFT_MIXER_EN_BIT]  = s_reg.hp_left_mixer_en;
        rd_word[HP_RIGHT_MIXER_EN_BIT] = s_reg.hp_right_mixer_en;
        rd_word[SPK_MIXER_EN_BIT]      = s_reg.spk_mixer_en;
      end
      ANTIPOP_BIAS_CONTROL_OFS: rd_word[STARTUP_BIAS_EN_BIT]    = s_reg.startup_bias_en;
      SEQUENCER_CONTROL_OFS:    rd_word[WRITE_SEQUENCER_EN_BIT] = s_reg.write_sequencer_en;
      CHARGE_PUMP_CONTROL_OFS:  rd_word[CHARGE_PUMP_EN_BIT]     = s_reg.charge_pump_en;
      DC_SERVO_CONTROL_OFS: begin
        rd_word[DC_SERVO_LEFT_EN_BIT]  = s_reg.dc_servo_left_en;
        rd_word[DC_SERVO_RIGHT_EN_BIT] = s_reg.dc_servo_right_en;
      end
      default: rd_word = 16'h0000;
    endcase
    //////////////////////////////////////////////////////////////////////////
    // control port byte engine
    if (start_cond) begin
      s_next.state     = ST_DEV_ADDR;
      s_next.cnt       = 4'h0;
      s_next.sda_drive = 1'b0;
    end else if (stop_cond) begin
      s_next.state     = ST_IDLE;
      s_next.sda_drive = 1'b0;
    end else begin
      unique case (s_reg.state)
        ST_DEV_ADDR, ST_REG_ADDR, ST_WR_HI, ST_WR_LO: begin
          if (scl_rise) begin
            s_next.shift = {s_reg.shift[6:0], sda_new};
            s_next.cnt   = s_reg.cnt + 4'h1;
          end else if (scl_fall && s_reg.cnt == BYTE_BITS) begin
            s_next.cnt       = 4'h0;
            s_next.sda_drive = 1'b1;
            unique case (s_reg.state)
              ST_DEV_ADDR: begin
                if (s_reg.shift[7:1] == BUS_DEV_ADDR) begin
                  s_next.rw    = s_reg.shift[0];
                  s_next.state = ST_DEV_ACK;
                end else begin
                  s_next.sda_drive = 1'b0;
                  s_next.state     = ST_IDLE;
                end
              end
              ST_REG_ADDR: begin
                s_next.ptr   = s_reg.shift;
                s_next.state = ST_REG_ACK;
              end
              ST_WR_HI: begin
                s_next.data_hi = s_reg.shift;
                s_next.state   = ST_WR_HI_ACK;
              end
              default: begin
                wr_en        = 1'b1;
                s_next.state = ST_WR_LO_ACK;
              end
            endcase
          end
        end
        ST_DEV_ACK, ST_REG_ACK, ST_WR_HI_ACK, ST_WR_LO_ACK: begin
          if (scl_fall) begin
            s_next.sda_drive = 1'b0;
            unique case (s_reg.state)
              ST_DEV_ACK: begin
                if (s_reg.rw) begin
                  s_next.shift     = rd_word[15:8];
                  s_next.sda_drive = ~rd_word[15];
                  s_next.state     = ST_RD_HI;
                end else begin
                  s_next.state = ST_REG_ADDR;
                end
              end
              ST_REG_ACK: s_next.state = ST_WR_HI;
              ST_WR_HI_ACK: s_next.state = ST_WR_LO;
              default: s_next.state = ST_WR_HI;
            endcase
          end
        end
        ST_RD_HI, ST_RD_LO: begin
          if (scl_rise) begin
            s_next.cnt = s_reg.cnt + 4'h1;
          end else if (scl_fall) begin
            if (s_reg.cnt == BYTE_BITS) begin
              s_next.cnt       = 4'h0;
              s_next.sda_drive = 1'b0;
              s_next.state     = (s_reg.state == ST_RD_HI) ? ST_RD_HI_ACK : ST_RD_LO_ACK;
            end else begin
              s_next.shift     = shifted;
              s_next.sda_drive = ~shifted[7];
            end
          end
        end
        ST_RD_HI_ACK, ST_RD_LO_ACK: begin
          if (scl_rise && sda_new) begin
            s_next.state = ST_IDLE;
          end else if (scl_fall) begin
            s_next.shift     = (s_reg.state == ST_RD_HI_ACK) ? rd_word[7:0] : rd_word[15:8];
            s_next.sda_drive = (s_reg.state == ST_RD_HI_ACK) ? ~rd_word[7] : ~rd_word[15];
            s_next.state     = (s_reg.state == ST_RD_HI_ACK) ? ST_RD_LO : ST_RD_HI;
          end
        end
        default: begin
          s_next.state     = ST_IDLE;
          s_next.sda_drive = 1'b0;
        end
      endcase
    end
    //////////////////////////////////////////////////////////////////////////
    // enables move only on a completed word write
    if (wr_en) begin
      unique case (s_reg.ptr)
        POWER_CONTROL_TWO_OFS: begin
          s_next.temp_sensor_en      = wr_data[TEMP_SENSOR_EN_BIT];
          s_next.overtemp_output_cut = wr_data[OVERTEMP_OUTPUT_CUT_BIT];
          s_next.input2_neg_gain_en  = wr_data[INPUT2_NEG_GAIN_EN_BIT];
        end
        POWER_CONTROL_THREE_OFS: begin
          s_next.spk_gain_stage_en = wr_data[SPK_GAIN_STAGE_EN_BIT];
          s_next.hp_left_mixer_en  = wr_data[HP_LEFT_MIXER_EN_BIT];
          s_next.hp_right_mixer_en = wr_data[HP_RIGHT_MIXER_EN_BIT];
          s_next.spk_mixer_en      = wr_data[SPK_MIXER_EN_BIT];
        end
        ANTIPOP_BIAS_CONTROL_OFS: s_next.startup_bias_en    = wr_data[STARTUP_BIAS_EN_BIT];
        SEQUENCER_CONTROL_OFS:    s_next.write_sequencer_en = wr_data[WRITE_SEQUENCER_EN_BIT];
        CHARGE_PUMP_CONTROL_OFS:  s_next.charge_pump_en     = wr_data[CHARGE_PUMP_EN_BIT];
        DC_SERVO_CONTROL_OFS: begin
          s_next.dc_servo_left_en  = wr_data[DC_SERVO_LEFT_EN_BIT];
          s_next.dc_servo_right_en = wr_data[DC_SERVO_RIGHT_EN_BIT];
        end
        default: begin
        end
      endcase
    end
    s_next.flag    = s_reg.temp_sensor_en & s_reg.det_f;
    // flag already gated by sensor enable
    s_next.spk_drv = SPK_OUT_REQ & ~(s_reg.overtemp_output_cut & s_reg.flag);
  end
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      s_reg <= STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  assign SDA_OUT            = 1'b0;
  assign SDA_OE             = s_reg.sda_drive;
  assign SPK_OUT_POS_EN     = s_reg.spk_drv;
  assign SPK_OUT_NEG_EN     = s_reg.spk_drv;
  assign OVERTEMP_FLAG      = s_reg.flag;
  assign TEMP_SENSOR_EN     = s_reg.temp_sensor_en;
  assign INPUT2_NEG_GAIN_EN = s_reg.input2_neg_gain_en;
  assign SPK_GAIN_STAGE_EN  = s_reg.spk_gain_stage_en;
  assign HP_LEFT_MIXER_EN   = s_reg.hp_left_mixer_en;
  assign HP_RIGHT_MIXER_EN  = s_reg.hp_right_mixer_en;
  assign SPK_MIXER_EN       = s_reg.spk_mixer_en;
  assign STARTUP_BIAS_EN    = s_reg.startup_bias_en;
  assign WRITE_SEQUENCER_EN = s_reg.write_sequencer_en;
  assign CHARGE_PUMP_EN     = s_reg.charge_pump_en;
  assign DC_SERVO_LEFT_EN   = s_reg.dc_servo_left_en;
  assign DC_SERVO_RIGHT_EN  = s_reg.dc_servo_right_en;
endmodule
`default_nettype wire

// ==== design/power_guard_pkg.sv ====
// register map, field positions and reset values of the power enable bank
// assumes registers are reached over the two-wire control port only
package power_guard_pkg;

  // seven-bit bus address of the device; value is arbitrary
  localparam logic [6:0] BUS_DEV_ADDR = 7'h36;

  localparam logic [7:0] POWER_CONTROL_TWO_OFS   = 8'h02;
  localparam logic [7:0] POWER_CONTROL_THREE_OFS = 8'h03;
  localparam logic [7:0] ANTIPOP_BIAS_CONTROL_OFS = 8'h39;
  localparam logic [7:0] SEQUENCER_CONTROL_OFS   = 8'h46;
  localparam logic [7:0] CHARGE_PUMP_CONTROL_OFS = 8'h4c;
  localparam logic [7:0] DC_SERVO_CONTROL_OFS    = 8'h54;

  localparam int OVERTEMP_FLAG_BIT       = 15;
  localparam int TEMP_SENSOR_EN_BIT      = 14;
  localparam int OVERTEMP_OUTPUT_CUT_BIT = 13;
  localparam int INPUT2_NEG_GAIN_EN_BIT  = 4;
  localparam int SPK_GAIN_STAGE_EN_BIT   = 8;
  localparam int HP_LEFT_MIXER_EN_BIT    = 5;
  localparam int HP_RIGHT_MIXER_EN_BIT   = 4;
  localparam int SPK_MIXER_EN_BIT        = 3;
  localparam int STARTUP_BIAS_EN_BIT     = 2;
  localparam int WRITE_SEQUENCER_EN_BIT  = 8;
  localparam int CHARGE_PUMP_EN_BIT      = 15;
  localparam int DC_SERVO_LEFT_EN_BIT    = 1;
  localparam int DC_SERVO_RIGHT_EN_BIT   = 0;

  localparam logic TEMP_SENSOR_EN_RST      = 1'b1;
  localparam logic OVERTEMP_OUTPUT_CUT_RST = 1'b1;
  localparam logic ENABLE_RST              = 1'b0;

  // bits per byte on the control port, counted including the last one
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_DEV_ADDR  = 4'h1,
    ST_DEV_ACK   = 4'h3,
    ST_REG_ADDR  = 4'h2,
    ST_REG_ACK   = 4'h6,
    ST_WR_HI     = 4'h7,
    ST_WR_HI_ACK = 4'h5,
    ST_WR_LO     = 4'h4,
    ST_WR_LO_ACK = 4'hc,
    ST_RD_HI     = 4'hd,
    ST_RD_HI_ACK = 4'hf,
    ST_RD_LO     = 4'he,
    ST_RD_LO_ACK = 4'ha
  } port_state_t;

endpackage

// ==== dv/power_guard_monitor.sv ====
// port-level assertions for the power enable bank and thermal guard
// assumes it is bound into power_guard; one clock, reset async high
`timescale 1ns/1ns
`default_nettype none
module power_guard_monitor (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic OVERTEMP_DET,
  input wire logic SPK_OUT_REQ,
  input wire logic SPK_OUT_POS_EN,
  input wire logic SPK_OUT_NEG_EN,
  input wire logic OVERTEMP_FLAG,
  input wire logic TEMP_SENSOR_EN,
  input wire logic INPUT2_NEG_GAIN_EN,
  input wire logic SPK_GAIN_STAGE_EN,
  input wire logic HP_LEFT_MIXER_EN,
  input wire logic HP_RIGHT_MIXER_EN,
  input wire logic SPK_MIXER_EN,
  input wire logic STARTUP_BIAS_EN,
  input wire logic WRITE_SEQUENCER_EN,
  input wire logic CHARGE_PUMP_EN,
  input wire logic DC_SERVO_LEFT_EN,
  input wire logic DC_SERVO_RIGHT_EN
);
  logic [10:0] en_bits;
  assign en_bits = {TEMP_SENSOR_EN, INPUT2_NEG_GAIN_EN, SPK_GAIN_STAGE_EN, HP_LEFT_MIXER_EN,
    HP_RIGHT_MIXER_EN, SPK_MIXER_EN, STARTUP_BIAS_EN, WRITE_SEQUENCER_EN, CHARGE_PUMP_EN,
    DC_SERVO_LEFT_EN, DC_SERVO_RIGHT_EN};
  default clocking mon_cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////////////
  oe_change_a:
    assert property ($changed(SDA_OE) |-> !SCL_IN) else $error("data pin moved with clock high");
  flag_live_a:
    assert property (!TEMP_SENSOR_EN [*2] |-> !OVERTEMP_FLAG) else $error("flag with sensor off");
  flag_hot_a:
    assert property ((OVERTEMP_DET && TEMP_SENSOR_EN) [*8] |-> OVERTEMP_FLAG)
      else $error("hot condition not flagged");
  flag_cool_a:
    assert property (!OVERTEMP_DET [*8] |-> !OVERTEMP_FLAG) else $error("flag without hot input");
  spk_pair_a:
    assert property (SPK_OUT_POS_EN == SPK_OUT_NEG_EN) else $error("speaker drivers disagree");
  spk_follow_a:
    assert property (!$past(OVERTEMP_FLAG) |-> SPK_OUT_POS_EN == $past(SPK_OUT_REQ))
      else $error("speaker enable not following request");
  spk_req_a:
    assert property (SPK_OUT_POS_EN |-> $past(SPK_OUT_REQ)) else $error("speaker on unrequested");
  en_write_a:
    assert property ($changed(en_bits) |-> !SCL_IN && !$past(SCL_IN, 3))
      else $error("enable changed outside a write");
  cover property (OVERTEMP_FLAG && SPK_OUT_REQ);
  cover property ($rose(SDA_OE));
  cover property ($fell(TEMP_SENSOR_EN));
endmodule
bind power_guard power_guard_monitor power_guard_monitor_inst (
  .SYS_CLK(SYS_CLK), .RST(RST), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE), .OVERTEMP_DET(OVERTEMP_DET), .SPK_OUT_REQ(SPK_OUT_REQ),
  .SPK_OUT_POS_EN(SPK_OUT_POS_EN), .SPK_OUT_NEG_EN(SPK_OUT_NEG_EN),
  .OVERTEMP_FLAG(OVERTEMP_FLAG), .TEMP_SENSOR_EN(TEMP_SENSOR_EN),
  .INPUT2_NEG_GAIN_EN(INPUT2_NEG_GAIN_EN), .SPK_GAIN_STAGE_EN(SPK_GAIN_STAGE_EN),
  .HP_LEFT_MIXER_EN(HP_LEFT_MIXER_EN), .HP_RIGHT_MIXER_EN(HP_RIGHT_MIXER_EN),
  .SPK_MIXER_EN(SPK_MIXER_EN), .STARTUP_BIAS_EN(STARTUP_BIAS_EN),
  .WRITE_SEQUENCER_EN(WRITE_SEQUENCER_EN), .CHARGE_PUMP_EN(CHARGE_PUMP_EN),
  .DC_SERVO_LEFT_EN(DC_SERVO_LEFT_EN), .DC_SERVO_RIGHT_EN(DC_SERVO_RIGHT_EN)
);
`default_nettype wire

// ==== dv/tb_power_guard.sv ====
// bench for power_guard: bit-banged control port, register and thermal checks
// assumes the design package is compiled first; inputs move on falling edges
`timescale 1ns/1ns
`default_nettype none
`define CHK(w, e, g) n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s expected %h seen %h", w, e, g); end
module tb_power_guard;
  import power_guard_pkg::*;
  logic        clk = 0;
  logic        rst = 1;
  logic        scl = 1;
  logic        sda_m = 1;
  logic        det = 0;
  logic        req = 0;
  logic        sda_oe;
  logic        sda_w;
  logic        sda_o;
  logic        pos_en;
  logic        neg_en;
  logic        flag;
  logic [10:0] en;
  int          fail_count = 0;
  int          n_tests = 0;
  logic [7:0]  ofs [6] = '{8'h02, 8'h03, 8'h39, 8'h46, 8'h4c, 8'h54};
  logic [15:0] onev [6] = '{16'h6010, 16'h0138, 16'h0004, 16'h0100, 16'h8000, 16'h0003};
  // open-drain wire: device pulls low
  assign sda_w = sda_m & ~sda_oe;
  power_guard power_guard_inst (
    .SYS_CLK(clk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda_w), .SDA_OUT(sda_o), .SDA_OE(sda_oe),
    .OVERTEMP_DET(det), .SPK_OUT_REQ(req), .SPK_OUT_POS_EN(pos_en), .SPK_OUT_NEG_EN(neg_en),
    .OVERTEMP_FLAG(flag), .TEMP_SENSOR_EN(en[10]), .INPUT2_NEG_GAIN_EN(en[9]),
    .SPK_GAIN_STAGE_EN(en[8]), .HP_LEFT_MIXER_EN(en[7]), .HP_RIGHT_MIXER_EN(en[6]),
    .SPK_MIXER_EN(en[5]), .STARTUP_BIAS_EN(en[4]), .WRITE_SEQUENCER_EN(en[3]),
    .CHARGE_PUMP_EN(en[2]), .DC_SERVO_LEFT_EN(en[1]), .DC_SERVO_RIGHT_EN(en[0]));
  initial forever #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tk(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one bit: data set mid-low, sampled mid-high
  task automatic bit_io(input logic v, output logic s);
    tk(5);
    sda_m = v;
    tk(5);
    scl = 1;
    tk(5);
    s = sda_w;
    tk(5);
    scl = 0;
  endtask
  task automatic strt;
    tk(5);
    sda_m = 1;
    tk(5);
    scl = 1;
    tk(5);
    sda_m = 0;
    tk(5);
    scl = 0;
  endtask
  task automatic stp;
    tk(5);
    sda_m = 0;
    tk(5);
    scl = 1;
    tk(5);
    sda_m = 1;
    tk(5);
  endtask
  task automatic wbyte(input logic [7:0] b, input logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    `CHK("ack", ack, ~s)
  endtask
  task automatic rbyte(output logic [7:0] d, input logic last);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s);
  endtask
  task automatic wr(input logic [7:0] r, input logic [15:0] d);
    strt();
    wbyte({BUS_DEV_ADDR, 1'b0}, 1'b1);
    wbyte(r, 1'b1);
    wbyte(d[15:8], 1'b1);
    wbyte(d[7:0], 1'b1);
    stp();
  endtask
  task automatic chk_rd(input logic [7:0] r, input logic [15:0] e);
    logic [15:0] d;
    strt();
    wbyte({BUS_DEV_ADDR, 1'b0}, 1'b1);
    wbyte(r, 1'b1);
    strt();
    wbyte({BUS_DEV_ADDR, 1'b1}, 1'b1);
    rbyte(d[15:8], 1'b0);
    rbyte(d[7:0], 1'b1);
    stp();
    `CHK("read", e, d)
  endtask
  task automatic close_out;
    if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    fail_count++;
    close_out();
  end
  initial begin
    tk(3);
    rst = 0;
    tk(10);
    `CHK("enables", 11'h400, en)
    `CHK("data out", 1'b0, sda_o)
    foreach (ofs[i]) begin
      chk_rd(ofs[i], (i == 0) ? 16'h6000 : 16'h0000);
      wr(ofs[i], 16'hffff);
      chk_rd(ofs[i], onev[i]);
    end
    `CHK("enables", 11'h7ff, en)
    foreach (ofs[i]) wr(ofs[i], 16'h0000);
    `CHK("enables", 11'h000, en)
    chk_rd(8'h02, 16'h0000);
    wr(8'h05, 16'hffff);
    chk_rd(8'h05, 16'h0000);
    strt();
    wbyte(8'ha0, 1'b0);
    stp();
    `CHK("enables", 11'h000, en)
    wr(8'h02, 16'h6000);
    req = 1;
    tk(3);
    `CHK("speaker", 1'b1, pos_en & neg_en)
    det = 1;
    tk(10);
    `CHK("flag", 1'b1, flag)
    `CHK("speaker", 1'b0, pos_en | neg_en)
    repeat (2) chk_rd(8'h02, 16'he000);
    // speaker request dropped around every sensor or cut change
    req = 0;
    wr(8'h02, 16'h4000);
    req = 1;
    tk(3);
    `CHK("speaker", 1'b1, pos_en & neg_en)
    req = 0;
    wr(8'h02, 16'h2000);
    req = 1;
    tk(3);
    `CHK("flag", 1'b0, flag)
    `CHK("speaker", 1'b1, pos_en & neg_en)
    chk_rd(8'h02, 16'h2000);
    det = 0;
    req = 0;
    wr(8'h02, 16'h6000);
    tk(10);
    `CHK("flag", 1'b0, flag)
    close_out();
  end
endmodule
`default_nettype wire
